// file: hw/amr_dev.sv
// device end: mode, output, command data and main status registers
//
// Summary of operation
// - encoder type field picks one of four modes
// - quadrature: A leading counts up
// - quad evaluation counts all edges of both
// - double evaluation counts both edges of A
// - single: A rise with B low up, A fall down
// - up/down mode: pulses on separate inputs
// - polarity bit inverts inputs, negative counts falling
// - swap bit exchanges inputs, reversing count except in single mode
// - limit swap exchanges plus and minus limits
// - triangle prevention enabled when bit zero
// - timer bit: zero once, one repeat
// - mode register clears at reset, top bit zero
// - xy output register drives X and Y pins
// - zu output register drives Z and U pins
// - data word split low/high, any order
// - data two's complement, zero after reset
// - driving flags in status bits 3 to 0
// - error flag is OR of axis detail bits and subchip error
// - error cleared by clear command or drive start
// - quadrant shown in status bits 10 to 8
// - next-node bit while interpolating and stack count one to seven
// - stack count shown in status bits 15 to 12
// - mode register goes to last commanded axis
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module amr_dev (
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	amr_bus_if.dev                            bus,
	input  wire logic [3:0]                   encoder_phase_a,
	input  wire logic [3:0]                   encoder_phase_b,
	input  wire logic [3:0]                   plus_limit_input,
	input  wire logic [3:0]                   minus_limit_input,
	input  wire logic [3:0]                   axis_driving_flag,
	input  wire logic [3:0]                   drive_start,
	input  wire logic [31:0]                  axis_error_detail,
	input  wire logic [3:0]                   subchip_error,
	input  wire logic [3:0]                   interp_active,
	input  wire logic [2:0]                   circle_quadrant,
	input  wire logic [3:0]                   stack_counter_value,
	output logic      [7:0]                   x_gp_pins,
	output logic      [7:0]                   y_gp_pins,
	output logic      [7:0]                   z_gp_pins,
	output logic      [7:0]                   u_gp_pins,
	output logic      [31:0]                  command_data_word,
	output logic      [3:0]                   axis_error_flag,
	output logic      [3:0]                   limit_plus_dir,
	output logic      [3:0]                   limit_minus_dir,
	output logic      [3:0]                   triangle_prevent_on,
	output logic      [3:0]                   timer_repeat_sel,
	output logic      [4*amr_pkg::AMR_RP_W-1:0] real_position_counter
);
	import amr_pkg::*;

	typedef struct packed {
		logic [3:0][15:0] mode3;
		logic [15:0]      gp_xy;
		logic [15:0]      gp_zu;
		logic [31:0]      cdata;
		logic [1:0]       axis;
		logic [3:0]       err;
		logic [3:0]       lp_s1;
		logic [3:0]       lp_s2;
		logic [3:0]       lm_s1;
		logic [3:0]       lm_s2;
		logic [15:0]      rdata;
	} amr_dev_st_t;

	amr_dev_st_t st_q;
	amr_dev_st_t st_d;
	logic [15:0] status;
	logic [3:0]  axis_sel;
	logic [3:0]  err_src;

	// =========================================================
	// status word assembled from live device state
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			err_src[i] = |axis_error_detail[8*i +: 8] | subchip_error[i];
		end
		status = '0;
		status[AMR_ST_DRV +: 4]  = axis_driving_flag;
		status[AMR_ST_ERR +: 4]  = st_q.err;
		status[AMR_ST_ZONE +: 3] = circle_quadrant;
		status[AMR_ST_NEXT]      = (|interp_active) && (stack_counter_value != 4'h0)
			&& (stack_counter_value < AMR_SC_FULL);
		status[AMR_ST_SC +: 4]   = stack_counter_value;
	end

	// =========================================================
	// register writes, read capture and error flags
	always_comb begin
		st_d = st_q;
		axis_sel = bus.wdata[AMR_CMD_AXIS_LSB +: 4];
		if (bus.wr) begin
			case (bus.addr)
				AMR_SEL_CMD: begin // last commanded axis
					if (axis_sel[3])
						st_d.axis = 2'h3;
					else if (axis_sel[2])
						st_d.axis = 2'h2;
					else if (axis_sel[1])
						st_d.axis = 2'h1;
					else if (axis_sel[0])
						st_d.axis = 2'h0;
				end
				AMR_SEL_MODE3: begin // top bit forced to zero
					st_d.mode3[st_q.axis] = {1'b0, bus.wdata[14:0]};
				end
				AMR_SEL_GPXY: begin
					st_d.gp_xy = bus.wdata;
				end
				AMR_SEL_GPZU: begin
					st_d.gp_zu = bus.wdata;
				end
				AMR_SEL_DLOW: begin
					st_d.cdata[15:0] = bus.wdata;
				end
				AMR_SEL_DHIGH: begin
					st_d.cdata[31:16] = bus.wdata;
				end
				default: begin
					st_d.axis = st_q.axis;
				end
			endcase
		end
		// clear first so a same-cycle error still sets the flag
		for (int i = 0; i < 4; i++) begin
			if ((bus.wr && bus.addr == AMR_SEL_CMD && bus.wdata[7:0] == AMR_CMD_ERRCLR
				&& axis_sel[i]) || drive_start[i])
				st_d.err[i] = 1'b0;
			if (err_src[i])
				st_d.err[i] = 1'b1;
		end
		// limit inputs through two stages before use
		st_d.lp_s1 = plus_limit_input;
		st_d.lp_s2 = st_q.lp_s1;
		st_d.lm_s1 = minus_limit_input;
		st_d.lm_s2 = st_q.lm_s1;
		// unmapped read selects answer zero
		st_d.rdata = '0;
		if (bus.rd && bus.addr == AMR_SEL_STATUS)
			st_d.rdata = status;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q       <= '0;
			st_q.gp_xy <= AMR_GP_RESET;
			st_q.gp_zu <= AMR_GP_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// =========================================================
	// per-axis encoder counters
	for (genvar g = 0; g < 4; g++) begin : g_axis
		amr_enc_count u_enc (
			.core_clk              (core_clk),
			.rst_n                 (rst_n),
			.enc_type              ({st_q.mode3[g][AMR_M3_TYPE_HI], st_q.mode3[g][AMR_M3_TYPE_LO]}),
			.enc_pol               (st_q.mode3[g][AMR_M3_POLARITY]),
			.enc_swap              (st_q.mode3[g][AMR_M3_SWAP]),
			.in_a                  (encoder_phase_a[g]),
			.in_b                  (encoder_phase_b[g]),
			.real_position_counter (real_position_counter[g*AMR_RP_W +: AMR_RP_W])
		);
		// limit mapping after synchronisation
		assign limit_plus_dir[g]  = st_q.mode3[g][AMR_M3_LIMSWAP] ? st_q.lm_s2[g]
			: st_q.lp_s2[g];
		assign limit_minus_dir[g] = st_q.mode3[g][AMR_M3_LIMSWAP] ? st_q.lp_s2[g]
			: st_q.lm_s2[g];
		assign triangle_prevent_on[g] = ~st_q.mode3[g][AMR_M3_TRI_OFF];
		assign timer_repeat_sel[g]    = st_q.mode3[g][AMR_M3_TIMER_REP];
	end

	// =========================================================
	// outputs
	assign x_gp_pins         = st_q.gp_xy[7:0];
	assign y_gp_pins         = st_q.gp_xy[15:8];
	assign z_gp_pins         = st_q.gp_zu[7:0];
	assign u_gp_pins         = st_q.gp_zu[15:8];
	assign command_data_word = st_q.cdata;
	assign axis_error_flag   = st_q.err;
	assign bus.rdata         = st_q.rdata;

endmodule : amr_dev

// file: hw/amr_pkg.sv
// package: register map, field positions, reset values and commands of the axis mode/status bank
package amr_pkg;

	// =========================================================
	// widths and register selects on the device data bus
	localparam int AMR_DW = 16;
	localparam int AMR_AW = 3;
	localparam logic [2:0] AMR_SEL_CMD    = 3'h0; // command write (low byte: code, bits 11:8 axis)
	localparam logic [2:0] AMR_SEL_MODE3  = 3'h3; // axis_mode_three
	localparam logic [2:0] AMR_SEL_GPXY   = 3'h4; // gp_output_xy
	localparam logic [2:0] AMR_SEL_GPZU   = 3'h5; // gp_output_zu
	localparam logic [2:0] AMR_SEL_DLOW   = 3'h6; // command_data_low
	localparam logic [2:0] AMR_SEL_DHIGH  = 3'h7; // command_data_high
	localparam logic [2:0] AMR_SEL_STATUS = 3'h0; // main_status (read)

	// =========================================================
	// axis_mode_three field positions
	localparam int AMR_M3_TYPE_LO   = 8;
	localparam int AMR_M3_TYPE_HI   = 9;
	localparam int AMR_M3_POLARITY  = 10;
	localparam int AMR_M3_SWAP      = 11;
	localparam int AMR_M3_LIMSWAP   = 12;
	localparam int AMR_M3_TRI_OFF   = 13;
	localparam int AMR_M3_TIMER_REP = 14;
	localparam int AMR_M3_RSVD      = 15;
	localparam logic [15:0] AMR_M3_RESET = 16'h0000;
	localparam logic [15:0] AMR_GP_RESET = 16'h0000;

	// encoder input types
	localparam logic [1:0] AMR_ENC_QUAD4 = 2'h0;
	localparam logic [1:0] AMR_ENC_QUAD2 = 2'h1;
	localparam logic [1:0] AMR_ENC_QUAD1 = 2'h2;
	localparam logic [1:0] AMR_ENC_UPDN  = 2'h3;

	// =========================================================
	// main_status field positions
	localparam int AMR_ST_DRV  = 0;
	localparam int AMR_ST_ERR  = 4;
	localparam int AMR_ST_ZONE = 8;
	localparam int AMR_ST_NEXT = 11;
	localparam int AMR_ST_SC   = 12;
	localparam logic [3:0] AMR_SC_FULL = 4'h8;

	// commands
	localparam logic [7:0] AMR_CMD_ERRCLR = 8'h79;
	localparam logic [7:0] AMR_CMD_NOP    = 8'h1f;
	localparam int AMR_CMD_AXIS_LSB = 8;
	localparam int AMR_RP_W = 32;

endpackage : amr_pkg

// file: hw/amr_bus_if.sv
// interface: device data bus between host end and the register bank end
`timescale 1ns/1ps
interface amr_bus_if;
	logic [amr_pkg::AMR_AW-1:0] addr;
	logic [amr_pkg::AMR_DW-1:0] wdata;
	logic                       wr;
	logic                       rd;
	logic [amr_pkg::AMR_DW-1:0] rdata;

	modport dev  (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : amr_bus_if

// file: hw/amr_enc_count.sv
// encoder decoder and real position counter for one axis
`timescale 1ns/1ps
module amr_enc_count (
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	input  wire logic [1:0]                   enc_type,
	input  wire logic                         enc_pol,
	input  wire logic                         enc_swap,
	input  wire logic                         in_a,
	input  wire logic                         in_b,
	output logic      [amr_pkg::AMR_RP_W-1:0] real_position_counter
);
	import amr_pkg::*;

	typedef struct packed {
		logic [1:0]          a_s;  // [0] first stage, [1] second
		logic [1:0]          b_s;
		logic                a_p;
		logic                b_p;
		logic [AMR_RP_W-1:0] rp;
	} amr_enc_st_t;

	amr_enc_st_t st_q;
	amr_enc_st_t st_d;
	logic        a;
	logic        b;
	logic        a_r;
	logic        a_f;
	logic        b_r;
	logic        b_f;
	logic        up;
	logic        dn;

	// =========================================================
	// decode on second-stage samples only
	always_comb begin
		st_d = st_q;
		st_d.a_s = {st_q.a_s[0], in_a};
		st_d.b_s = {st_q.b_s[0], in_b};
		// swap then polarity; swap reverses direction in every type except AMR_ENC_QUAD1
		a = (enc_swap ? st_q.b_s[1] : st_q.a_s[1]) ^ enc_pol;
		b = (enc_swap ? st_q.a_s[1] : st_q.b_s[1]) ^ enc_pol;
		st_d.a_p = a;
		st_d.b_p = b;
		a_r = a & ~st_q.a_p;
		a_f = ~a & st_q.a_p;
		b_r = b & ~st_q.b_p;
		b_f = ~b & st_q.b_p;
		up = 1'b0;
		dn = 1'b0;
		case (enc_type)
			AMR_ENC_QUAD4: begin // a leads b counts up
				up = (a_r & ~b) | (a_f & b) | (b_r & a) | (b_f & ~a);
				dn = (a_r & b) | (a_f & ~b) | (b_r & ~a) | (b_f & a);
			end
			AMR_ENC_QUAD2: begin
				up = (a_r & ~b) | (a_f & b);
				dn = (a_r & b) | (a_f & ~b);
			end
			AMR_ENC_QUAD1: begin
				up = a_r & ~b;
				dn = a_f;
			end
			AMR_ENC_UPDN: begin // rising edge of active pulse
				up = a_r;
				dn = b_r;
			end
			default: begin
				up = 1'b0;
				dn = 1'b0;
			end
		endcase
		// simultaneous up and down cancel out
		if (up & ~dn)
			st_d.rp = st_q.rp + AMR_RP_W'(1);
		else if (dn & ~up)
			st_d.rp = st_q.rp - AMR_RP_W'(1);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign real_position_counter = st_q.rp;

endmodule : amr_enc_count

// file: hw/amr_host.sv
// host end: software port turned into device bus cycles
`timescale 1ns/1ps
module amr_host (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	amr_bus_if.host          bus,
	input  wire logic [2:0]  sw_addr,
	input  wire logic [15:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic      [15:0] sw_rdata
);
	import amr_pkg::*;

	typedef struct packed {
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} amr_host_st_t;

	amr_host_st_t st_q;
	amr_host_st_t st_d;

	// =========================================================
	// forward each strobe one cycle later, a read only when no write comes with it; mode top bit forced low
	always_comb begin
		st_d       = st_q;
		st_d.addr  = sw_addr;
		st_d.wdata = sw_wdata;
		st_d.wr    = sw_wr;
		st_d.rd    = sw_rd & ~sw_wr;
		if (sw_addr == AMR_SEL_MODE3)
			st_d.wdata[AMR_M3_RSVD] = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// data halves pass in whatever order software writes
	assign bus.addr  = st_q.addr;
	assign bus.wdata = st_q.wdata;
	assign bus.wr    = st_q.wr;
	assign bus.rd    = st_q.rd;
	assign sw_rdata  = bus.rdata;

endmodule : amr_host

// file: tb/amr_chk.sv
// checker: device bus and register output relations of the mode/status bank
`timescale 1ns/1ps
module amr_chk
	import amr_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [2:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic [7:0]  x_gp_pins,
	input wire logic [7:0]  y_gp_pins,
	input wire logic [7:0]  z_gp_pins,
	input wire logic [7:0]  u_gp_pins,
	input wire logic [31:0] command_data_word
);
	// ==========
	// write cycles by target register
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr_xy; wr && addr == AMR_SEL_GPXY; endsequence
	sequence s_wr_zu; wr && addr == AMR_SEL_GPZU; endsequence
	sequence s_wr_lo; wr && addr == AMR_SEL_DLOW; endsequence
	sequence s_wr_hi; wr && addr == AMR_SEL_DHIGH; endsequence
	// ==========
	// read path: data only in the cycle after a status read
	a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data without a read");
	a_rd_only_status: assert property (rd && addr != AMR_SEL_STATUS |=> rdata == 16'h0000)
		else $error("write-only register read back");
	a_strobe_excl: assert property (!(wr && rd))
		else $error("read and write strobes together");
	// ==========
	// output registers load from the bus; xy pins checked to hold in cycles with no write
	a_xy_load: assert property (s_wr_xy |=> {y_gp_pins, x_gp_pins} == $past(wdata))
		else $error("xy pins not loaded");
	a_xy_hold: assert property (!wr |=> $stable({y_gp_pins, x_gp_pins}))
		else $error("xy pins changed without write");
	a_zu_load: assert property (s_wr_zu |=> {u_gp_pins, z_gp_pins} == $past(wdata))
		else $error("zu pins not loaded");
	a_data_low: assert property (s_wr_lo |=> command_data_word[15:0] == $past(wdata)
		&& $stable(command_data_word[31:16]))
		else $error("low data half wrong");
	a_data_high: assert property (s_wr_hi |=> command_data_word[31:16] == $past(wdata)
		&& $stable(command_data_word[15:0]))
		else $error("high data half wrong");
endmodule : amr_chk

// file: tb/testbench.sv
// testbench: host and device ends joined by the bus, driven via the software port
`timescale 1ns/1ps
module testbench;
	import amr_pkg::*;
	logic         core_clk, rst_n, sw_wr, sw_rd;
	logic [2:0]   sw_addr, circle_quadrant;
	logic [15:0]  sw_wdata, sw_rdata, rv;
	logic [3:0]   encoder_phase_a, encoder_phase_b, plus_limit_input, minus_limit_input;
	logic [3:0]   axis_driving_flag, drive_start, subchip_error, interp_active;
	logic [3:0]   stack_counter_value, axis_error_flag, limit_plus_dir, limit_minus_dir;
	logic [3:0]   triangle_prevent_on, timer_repeat_sel;
	logic [7:0]   x_gp_pins, y_gp_pins, z_gp_pins, u_gp_pins;
	logic [31:0]  axis_error_detail, command_data_word, exp_rp;
	logic [127:0] real_position_counter;
	int           fail_count, checks_done;
	// mode word, four encoder steps {a,b}, expected count change
	// last entry: up/down with negative logic, counts on falling pin edges
	logic [31:0]  mtab [7] = '{32'h0000b404, 32'h2100b402, 32'h420078ff,
		32'h13008802, 32'h6800b4fc, 32'h1b0088fe, 32'h07008802};

	amr_bus_if bus_i ();
	amr_host u_amr_host (.core_clk, .rst_n, .bus(bus_i.host), .sw_addr, .sw_wdata, .sw_wr,
		.sw_rd, .sw_rdata);
	amr_dev u_amr_dev (.core_clk, .rst_n, .bus(bus_i.dev), .encoder_phase_a, .encoder_phase_b,
		.plus_limit_input, .minus_limit_input, .axis_driving_flag, .drive_start,
		.axis_error_detail, .subchip_error, .interp_active, .circle_quadrant,
		.stack_counter_value, .x_gp_pins, .y_gp_pins, .z_gp_pins, .u_gp_pins,
		.command_data_word, .axis_error_flag, .limit_plus_dir, .limit_minus_dir,
		.triangle_prevent_on, .timer_repeat_sel, .real_position_counter);
	amr_chk u_amr_chk (.core_clk, .rst_n, .addr(bus_i.addr), .wdata(bus_i.wdata),
		.wr(bus_i.wr), .rd(bus_i.rd), .rdata(bus_i.rdata), .x_gp_pins, .y_gp_pins,
		.z_gp_pins, .u_gp_pins, .command_data_word);

	// ==========
	// access tasks
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask : sw_write
	// answer stands only two edges after the request, so sample just then
	task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		@(posedge core_clk);
		#1 d = sw_rdata;
	endtask : sw_read
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	// ==========
	// clock and watchdog (sequence needs about 370 cycles)
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		fail_count++;
		summarize();
	end

	// ==========
	// main sequence
	initial begin
		{fail_count, checks_done, exp_rp} = '0;
		{rst_n, sw_wr, sw_rd, sw_addr, sw_wdata, circle_quadrant} = '0;
		{encoder_phase_a, encoder_phase_b, minus_limit_input, drive_start} = '0;
		{subchip_error, interp_active, stack_counter_value, axis_error_detail} = '0;
		plus_limit_input = 4'h1;
		axis_driving_flag = 4'ha;
		tick(6);
		rst_n <= 1'b1;
		tick(2);
		check("reset_mode", 32'hf0, {triangle_prevent_on, timer_repeat_sel});
		check("reset_rp", 32'h0, real_position_counter[31:0]);
		// output pins and command data, both halves in both orders
		sw_write(AMR_SEL_GPXY, 16'ha5c3);
		sw_write(AMR_SEL_GPZU, 16'h3c5a);
		sw_write(AMR_SEL_DHIGH, 16'hfffe);
		sw_write(AMR_SEL_DLOW, 16'h1234);
		tick(2);
		check("gp_pins", 32'ha5c33c5a, {y_gp_pins, x_gp_pins, u_gp_pins, z_gp_pins});
		check("data_word", 32'hfffe1234, command_data_word);
		sw_write(AMR_SEL_DLOW, 16'h0001);
		sw_write(AMR_SEL_DHIGH, 16'h8000);
		tick(2);
		check("data_word", 32'h80000001, command_data_word);
		sw_read(AMR_SEL_GPXY, rv);
		check("wo_read", 32'h0, rv);
		// status fields across stack counts 0 to 8
		interp_active <= 4'h1;
		for (int i = 0; i <= 8; i++) begin
			stack_counter_value <= 4'(i);
			circle_quadrant <= 3'(i);
			sw_read(AMR_SEL_STATUS, rv);
			check("status", {4'(i), i > 0 && i < 8, 3'(i), 8'h0a}, rv);
		end
		interp_active <= 4'h0;
		stack_counter_value <= 4'h3;
		circle_quadrant <= 3'h3;
		sw_read(AMR_SEL_STATUS, rv);
		check("status_idle", 32'h330a, rv);
		// error flag set, held, cleared by command and by drive start
		axis_error_detail <= 32'h00000800;
		tick(1);
		axis_error_detail <= 32'h0;
		tick(4);
		check("err_flag", 32'h2, axis_error_flag);
		sw_read(AMR_SEL_STATUS, rv);
		check("status_err", 32'h332a, rv);
		sw_write(AMR_SEL_CMD, {4'h0, 4'h2, AMR_CMD_ERRCLR});
		tick(3);
		check("err_clear", 32'h0, axis_error_flag);
		subchip_error <= 4'h4;
		tick(1);
		subchip_error <= 4'h0;
		tick(4);
		check("err_sub", 32'h4, axis_error_flag);
		drive_start <= 4'h4;
		tick(1);
		drive_start <= 4'h0;
		tick(3);
		check("err_start", 32'h0, axis_error_flag);
		// mode table on axis 0: decoding, swaps, triangle and timer bits
		sw_write(AMR_SEL_CMD, {4'h0, 4'h1, AMR_CMD_NOP});
		for (int k = 0; k < 7; k++) begin
			sw_write(AMR_SEL_MODE3, mtab[k][31:16]);
			tick(6);
			check("mode_out", {~mtab[k][29], mtab[k][30], mtab[k][28], ~mtab[k][28]},
				{triangle_prevent_on[0], timer_repeat_sel[0], limit_minus_dir[0],
				limit_plus_dir[0]});
			for (int s = 3; s >= 0; s--) begin
				encoder_phase_a[0] <= mtab[k][9 + 2 * s];
				encoder_phase_b[0] <= mtab[k][8 + 2 * s];
				tick(8);
			end
			exp_rp = exp_rp + {{24{mtab[k][7]}}, mtab[k][7:0]};
			check("rp", exp_rp, real_position_counter[31:0]);
		end
		// a later command moves the mode register to axis 2
		sw_write(AMR_SEL_CMD, {4'h0, 4'h4, AMR_CMD_NOP});
		sw_write(AMR_SEL_MODE3, 16'h2000);
		tick(3);
		check("tri_axes", 32'hb, triangle_prevent_on);
		summarize();
	end
endmodule : testbench
